/* pkg/gpio_pkg.sv */
package gpio_pkg;
    localparam int PA_PINS = 23;
    localparam int PB_PINS = 11;
    localparam int IRQ_LINES = 24;
    localparam int WAKE_LINES = 8;
    localparam int FILT_FIRST = 8;
    localparam int FILT_LINES = 16;
    localparam int TRIG_FIELD_W = 4;
    localparam int FILT_FIELD_W = 4;
    localparam int FILT_EN_BIT = 3;
    localparam int PA_RESET_OUT_PIN = 21;

    // register byte addresses
    localparam logic [31:0] PA_FSEL_ADDR = 32'h5600_0000;
    localparam logic [31:0] PA_DATA_ADDR = 32'h5600_0004;
    localparam logic [31:0] PB_FSEL_ADDR = 32'h5600_0010;
    localparam logic [31:0] PB_DATA_ADDR = 32'h5600_0014;
    localparam logic [31:0] PB_PUD_ADDR = 32'h5600_0018;
    localparam logic [31:0] MISC_ADDR = 32'h5600_0080;
    localparam logic [31:0] TRIG0_ADDR = 32'h5600_0084;
    localparam logic [31:0] TRIG1_ADDR = 32'h5600_0088;
    localparam logic [31:0] TRIG2_ADDR = 32'h5600_008C;
    localparam logic [31:0] FILT0_ADDR = 32'h5600_0090;
    localparam logic [31:0] FILT1_ADDR = 32'h5600_0094;
    localparam logic [31:0] IRQ_STATUS_ADDR = 32'h5600_0098;
    localparam logic [31:0] IRQ_ENABLE_ADDR = 32'h5600_009C;

    // reset values
    localparam logic [22:0] PA_FSEL_RST = 23'h7F_FFFF;
    localparam logic [22:0] PA_DATA_RST = 23'h00_0000;
    localparam logic [21:0] PB_FSEL_RST = 22'h00_0000;
    localparam logic [10:0] PB_DATA_RST = 11'h000;
    localparam logic [10:0] PB_PUD_RST = 11'h000;
    localparam logic [6:0] MISC_RST = 7'h00;
    localparam logic [95:0] TRIG_RST = 96'h0000_0000_0000_0000_0000_0000;
    localparam logic [63:0] FILT_RST = 64'h0000_0000_0000_0000;

    // misc control field positions
    localparam int MISC_DBUS_PUD_BIT = 0;
    localparam int MISC_STOP_HOLD_BIT = 1;
    localparam int MISC_USB_LSB = 2;
    localparam int MISC_CLKOUT_LSB = 4;

    typedef enum logic [1:0] {
        PB_MODE_IN = 2'h0,
        PB_MODE_OUT = 2'h1,
        PB_MODE_FUNC = 2'h2,
        PB_MODE_RSVD = 2'h3
    } pb_mode_t;

    typedef enum logic [2:0] {
        TRIG_LOW = 3'h0,
        TRIG_HIGH = 3'h1,
        TRIG_FALL = 3'h2,
        TRIG_RISE = 3'h3,
        TRIG_BOTH = 3'h4
    } trig_t;

    typedef struct packed {
        logic [10:0] out;
        logic [10:0] oe;
        logic [10:0] pullup_en;
    } pb_pad_t;
endpackage

/* hw/gpio_port_ctrl.sv */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_ctrl (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic [22:0] PA_FUNC_OUT,
    input wire logic EXT_RESET_PIN_N,
    input wire logic WATCHDOG_RESET_N,
    input wire logic SOFTWARE_RESET_N,
    output logic [22:0] PA_OUT,
    input wire logic [10:0] PB_PIN_IN,
    input wire logic [10:0] PB_FUNC_OUT,
    input wire logic [10:0] PB_FUNC_OE,
    output gpio_pkg::pb_pad_t PB_PAD,
    output logic [10:0] PB_FUNC_IN,
    input wire logic [23:0] EXTERNAL_IRQ_LINE,
    output logic IRQ,
    output logic WAKE,
    output logic DBUS_PULLUP_EN,
    output logic STOP_HOLD,
    output logic [1:0] USB_PAD_SEL,
    output logic [2:0] CLKOUT_SEL
);
    logic [22:0] pa_fsel_q;
    logic [22:0] pa_data_q;
    logic [21:0] pb_fsel_q;
    logic [10:0] pb_data_q;
    logic [10:0] pb_pud_q;
    logic [6:0] misc_q;
    logic [95:0] trig_q;
    logic [63:0] filt_q;
    logic [23:0] status_q;
    logic [23:0] enable_q;
    logic [10:0] pb_in_m_q;
    logic [10:0] pb_in_s_q;
    logic [23:0] line_m_q;
    logic [23:0] line_s_q;
    logic rst_pin_m_q;
    logic rst_pin_s_q;
    logic [23:0] line_f;
    logic [23:0] prev_q;
    logic [23:0] event_d;
    logic [10:0] pb_rd;
    logic [10:0] pb_out_d;
    logic [10:0] pb_oe_d;
    logic [22:0] pa_out_d;
    logic [31:0] rdata_d;
    logic [22:0] pa_out_q;
    logic [32:0] pb_pad_q;
    logic [10:0] pb_func_in_q;
    logic [31:0] rdata_q;
    logic irq_q;
    logic wake_q;
    logic dbus_pu_q;
    logic wr_pa_fsel;
    logic wr_pa_data;
    logic wr_pb_fsel;
    logic wr_pb_data;
    logic wr_pb_pud;
    logic wr_misc;
    logic wr_status;
    logic wr_enable;

    // address decode; any other address is write-ignored
    assign wr_pa_fsel = WR && (ADDR == gpio_pkg::PA_FSEL_ADDR);
    assign wr_pa_data = WR && (ADDR == gpio_pkg::PA_DATA_ADDR);
    assign wr_pb_fsel = WR && (ADDR == gpio_pkg::PB_FSEL_ADDR);
    assign wr_pb_data = WR && (ADDR == gpio_pkg::PB_DATA_ADDR);
    assign wr_pb_pud = WR && (ADDR == gpio_pkg::PB_PUD_ADDR);
    assign wr_misc = WR && (ADDR == gpio_pkg::MISC_ADDR);
    assign wr_status = WR && (ADDR == gpio_pkg::IRQ_STATUS_ADDR);
    assign wr_enable = WR && (ADDR == gpio_pkg::IRQ_ENABLE_ADDR);

    // pin synchronisers
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pb_in_m_q <= 11'h000;
            pb_in_s_q <= 11'h000;
            line_m_q <= 24'h00_0000;
            line_s_q <= 24'h00_0000;
            rst_pin_m_q <= 1'b0;
            rst_pin_s_q <= 1'b0;
        end else if (CE) begin
            pb_in_m_q <= PB_PIN_IN;
            pb_in_s_q <= pb_in_m_q;
            line_m_q <= EXTERNAL_IRQ_LINE;
            line_s_q <= line_m_q;
            rst_pin_m_q <= EXT_RESET_PIN_N;
            rst_pin_s_q <= rst_pin_m_q;
        end
    end

    // port A registers
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pa_fsel_q <= gpio_pkg::PA_FSEL_RST;
            pa_data_q <= gpio_pkg::PA_DATA_RST;
        end else if (CE) begin
            if (wr_pa_fsel) begin
                pa_fsel_q <= WDATA[22:0];
            end
            if (wr_pa_data) begin
                pa_data_q <= WDATA[22:0];
            end
        end
    end

    // port B registers
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pb_fsel_q <= gpio_pkg::PB_FSEL_RST;
            pb_data_q <= gpio_pkg::PB_DATA_RST;
            pb_pud_q <= gpio_pkg::PB_PUD_RST;
        end else if (CE) begin
            if (wr_pb_fsel) begin
                pb_fsel_q <= WDATA[21:0];
            end
            if (wr_pb_data) begin
                pb_data_q <= WDATA[10:0];
            end
            if (wr_pb_pud) begin
                pb_pud_q <= WDATA[10:0];
            end
        end
    end

    // misc, trigger and filter configuration
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            misc_q <= gpio_pkg::MISC_RST;
            trig_q <= gpio_pkg::TRIG_RST;
            filt_q <= gpio_pkg::FILT_RST;
        end else if (CE && WR) begin
            unique case (ADDR)
                gpio_pkg::MISC_ADDR: misc_q <= WDATA[6:0];
                gpio_pkg::TRIG0_ADDR: trig_q[31:0] <= WDATA;
                gpio_pkg::TRIG1_ADDR: trig_q[63:32] <= WDATA;
                gpio_pkg::TRIG2_ADDR: trig_q[95:64] <= WDATA;
                gpio_pkg::FILT0_ADDR: filt_q[31:0] <= WDATA;
                gpio_pkg::FILT1_ADDR: filt_q[63:32] <= WDATA;
                default: ;
            endcase
        end
    end

    // port A pad: output data or memory function, pin 21 resets
    always_comb begin
        for (int i = 0; i < gpio_pkg::PA_PINS; i++) begin
            pa_out_d[i] = pa_fsel_q[i] ? PA_FUNC_OUT[i] : pa_data_q[i];
        end
        if (pa_fsel_q[gpio_pkg::PA_RESET_OUT_PIN]) begin
            pa_out_d[gpio_pkg::PA_RESET_OUT_PIN] =
                rst_pin_s_q & WATCHDOG_RESET_N & SOFTWARE_RESET_N;
        end
    end

    // port B pad, per pin
    for (genvar g = 0; g < gpio_pkg::PB_PINS; g++) begin : g_pb
        gpio_pkg::pb_mode_t mode;
        assign mode = gpio_pkg::pb_mode_t'(pb_fsel_q[2 * g +: 2]);
        // reserved and input both leave the driver off
        assign pb_out_d[g] = (mode == gpio_pkg::PB_MODE_OUT) ? pb_data_q[g]
                                                              : PB_FUNC_OUT[g];
        assign pb_oe_d[g] = (mode == gpio_pkg::PB_MODE_OUT) ||
                            ((mode == gpio_pkg::PB_MODE_FUNC) && PB_FUNC_OE[g]);
        // function pins read the pin level, which software must not trust
        assign pb_rd[g] = (mode == gpio_pkg::PB_MODE_OUT) ? pb_data_q[g]
                                                           : pb_in_s_q[g];
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pa_out_q <= gpio_pkg::PA_DATA_RST;
            pb_pad_q <= {22'h00_0000, 11'h7FF};
            pb_func_in_q <= 11'h000;
        end else if (CE) begin
            pa_out_q <= pa_out_d;
            pb_pad_q <= {pb_out_d, pb_oe_d, ~pb_pud_q};
            pb_func_in_q <= pb_in_s_q;
        end
    end

    // external lines: optional filter, then trigger detection
    for (genvar g = 0; g < gpio_pkg::IRQ_LINES; g++) begin : g_line
        gpio_pkg::trig_t trig;
        assign trig = gpio_pkg::trig_t'(trig_q[g * gpio_pkg::TRIG_FIELD_W +: 3]);
        if (g >= gpio_pkg::FILT_FIRST) begin : g_filt
            localparam int F = g - gpio_pkg::FILT_FIRST;
            logic [2:0] cnt_q;
            logic val_q;
            logic en;
            logic [2:0] len;
            assign en = filt_q[F * gpio_pkg::FILT_FIELD_W + gpio_pkg::FILT_EN_BIT];
            assign len = filt_q[F * gpio_pkg::FILT_FIELD_W +: 3];
            // a change passes only after standing len+1 samples
            always_ff @(posedge CLK) begin
                if (!RST_B) begin
                    cnt_q <= 3'h0;
                    val_q <= 1'b0;
                end else if (CE) begin
                    if (!en || (line_s_q[g] == val_q)) begin
                        cnt_q <= 3'h0;
                        val_q <= en ? val_q : line_s_q[g];
                    end else if (cnt_q == len) begin
                        cnt_q <= 3'h0;
                        val_q <= line_s_q[g];
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
            end
            assign line_f[g] = val_q;
        end else begin : g_raw
            assign line_f[g] = line_s_q[g];
        end
        always_comb begin
            unique case (trig)
                gpio_pkg::TRIG_LOW: event_d[g] = !line_f[g];
                gpio_pkg::TRIG_HIGH: event_d[g] = line_f[g];
                gpio_pkg::TRIG_FALL: event_d[g] = prev_q[g] && !line_f[g];
                gpio_pkg::TRIG_RISE: event_d[g] = !prev_q[g] && line_f[g];
                default: event_d[g] = prev_q[g] != line_f[g];
            endcase
        end
    end

    // sticky status, write one to clear, a new event wins
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            prev_q <= 24'h00_0000;
            status_q <= 24'h00_0000;
            enable_q <= 24'h00_0000;
        end else if (CE) begin
            prev_q <= line_f;
            status_q <= (status_q & ~(wr_status ? WDATA[23:0] : 24'h00_0000)) | event_d;
            if (wr_enable) begin
                enable_q <= WDATA[23:0];
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else if (CE) begin
            irq_q <= |(status_q & enable_q);
            wake_q <= |(status_q[7:0] & enable_q[7:0]);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            dbus_pu_q <= !gpio_pkg::MISC_RST[gpio_pkg::MISC_DBUS_PUD_BIT];
        end else if (CE) begin
            dbus_pu_q <= !misc_q[gpio_pkg::MISC_DBUS_PUD_BIT];
        end
    end

    // read mux; unmapped and reserved words read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (ADDR)
            gpio_pkg::PA_FSEL_ADDR: rdata_d[22:0] = pa_fsel_q;
            gpio_pkg::PA_DATA_ADDR: rdata_d[22:0] = pa_data_q;
            gpio_pkg::PB_FSEL_ADDR: rdata_d[21:0] = pb_fsel_q;
            gpio_pkg::PB_DATA_ADDR: rdata_d[10:0] = pb_rd;
            gpio_pkg::PB_PUD_ADDR: rdata_d[10:0] = pb_pud_q;
            gpio_pkg::MISC_ADDR: rdata_d[6:0] = misc_q;
            gpio_pkg::TRIG0_ADDR: rdata_d = trig_q[31:0];
            gpio_pkg::TRIG1_ADDR: rdata_d = trig_q[63:32];
            gpio_pkg::TRIG2_ADDR: rdata_d = trig_q[95:64];
            gpio_pkg::FILT0_ADDR: rdata_d = filt_q[31:0];
            gpio_pkg::FILT1_ADDR: rdata_d = filt_q[63:32];
            gpio_pkg::IRQ_STATUS_ADDR: rdata_d[23:0] = status_q;
            gpio_pkg::IRQ_ENABLE_ADDR: rdata_d[23:0] = enable_q;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            rdata_q <= 32'h0000_0000;
        end else if (CE) begin
            rdata_q <= RD ? rdata_d : 32'h0000_0000;
        end
    end

    assign RDATA = rdata_q;
    assign PA_OUT = pa_out_q;
    assign PB_PAD = gpio_pkg::pb_pad_t'(pb_pad_q);
    assign PB_FUNC_IN = pb_func_in_q;
    assign IRQ = irq_q;
    assign WAKE = wake_q;
    assign DBUS_PULLUP_EN = dbus_pu_q;
    assign STOP_HOLD = misc_q[gpio_pkg::MISC_STOP_HOLD_BIT];
    assign USB_PAD_SEL = misc_q[gpio_pkg::MISC_USB_LSB +: 2];
    assign CLKOUT_SEL = misc_q[gpio_pkg::MISC_CLKOUT_LSB +: 3];

    property p_pa_out_data;
        @(posedge CLK) disable iff (!RST_B)
        CE |=> ((PA_OUT ^ $past(pa_data_q)) & ~$past(pa_fsel_q)) == 23'h00_0000;
    endproperty
    a_pa_out_data: assert property (p_pa_out_data) else $error("port A pin differs from data");

    property p_reset_out;
        @(posedge CLK) disable iff (!RST_B)
        CE && pa_fsel_q[gpio_pkg::PA_RESET_OUT_PIN] |=> PA_OUT[gpio_pkg::PA_RESET_OUT_PIN] ==
            ($past(rst_pin_s_q) & $past(WATCHDOG_RESET_N) & $past(SOFTWARE_RESET_N));
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("reset output not the AND");

    property p_pb_read_in;
        @(posedge CLK) disable iff (!RST_B)
        CE && RD && ADDR == gpio_pkg::PB_DATA_ADDR && pb_fsel_q[1:0] == 2'h0
            |=> RDATA[0] == $past(pb_in_s_q[0]);
    endproperty
    a_pb_read_in: assert property (p_pb_read_in) else $error("input pin read wrong");

    property p_pullup;
        @(posedge CLK) disable iff (!RST_B)
        CE |=> PB_PAD.pullup_en == ~$past(pb_pud_q);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up enable wrong");

    property p_pb_out_drive;
        @(posedge CLK) disable iff (!RST_B)
        CE && pb_fsel_q[3:2] == 2'h1 |=> PB_PAD.oe[1] && PB_PAD.out[1] == $past(pb_data_q[1]);
    endproperty
    a_pb_out_drive: assert property (p_pb_out_drive) else $error("output pin not driven");

    property p_rsvd_off;
        @(posedge CLK) disable iff (!RST_B)
        CE && pb_fsel_q[1:0] == 2'h3 |=> !PB_PAD.oe[0];
    endproperty
    a_rsvd_off: assert property (p_rsvd_off) else $error("reserved field drives pin");

    property p_pb_reset;
        @(posedge CLK)
        !RST_B |=> pb_fsel_q == 22'h00_0000 && pb_pud_q == 11'h000;
    endproperty
    a_pb_reset: assert property (p_pb_reset) else $error("port B not reset to zero");

    property p_rise_event;
        @(posedge CLK) disable iff (!RST_B)
        CE && trig_q[10:8] == 3'h3 && !prev_q[2] && line_f[2] |=> status_q[2];
    endproperty
    a_rise_event: assert property (p_rise_event) else $error("rising edge lost");

    property p_wake_low_only;
        @(posedge CLK) disable iff (!RST_B)
        CE |=> WAKE == |($past(status_q[7:0]) & $past(enable_q[7:0]));
    endproperty
    a_wake_low_only: assert property (p_wake_low_only) else $error("wake source wrong");

    property p_rsvd_read;
        @(posedge CLK) disable iff (!RST_B)
        CE && RD && ADDR == 32'h5600_0008 |=> RDATA == 32'h0000_0000;
    endproperty
    a_rsvd_read: assert property (p_rsvd_read) else $error("reserved word not zero");

    property p_filter_hold;
        @(posedge CLK) disable iff (!RST_B)
        CE && filt_q[19] && line_s_q[12] != line_f[12] &&
            g_line[12].g_filt.cnt_q != filt_q[18:16] |=> $stable(line_f[12]);
    endproperty
    a_filter_hold: assert property (p_filter_hold) else $error("filter passed early");

    property p_set_wins;
        @(posedge CLK) disable iff (!RST_B)
        CE && wr_status && WDATA[0] && event_d[0] |=> status_q[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
endmodule
`default_nettype wire

/* test/gpio_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_board_model (
    input wire logic CLK,
    input wire gpio_pkg::pb_pad_t PAD,
    input wire logic [10:0] EXT_EN,
    input wire logic [10:0] EXT_VAL,
    output logic [10:0] PIN
);
    logic flip_q = 1'b0;
    // floating pins wander so a stale level never passes
    always @(posedge CLK) begin
        flip_q <= ~flip_q;
    end
    always_comb begin
        for (int i = 0; i < 11; i++) begin
            if (PAD.oe[i]) begin
                PIN[i] = PAD.out[i];
            end else if (EXT_EN[i]) begin
                PIN[i] = EXT_VAL[i];
            end else if (PAD.pullup_en[i]) begin
                PIN[i] = 1'b1;
            end else begin
                PIN[i] = flip_q ^ i[0];
            end
        end
    end
endmodule
`default_nettype wire

/* test/tb_multiplexed_pin_port_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_multiplexed_pin_port_control;
    logic clk, rst_b, ce, wr, rd, ext_rst_n, wdt_rst_n, sw_rst_n;
    logic [31:0] addr, wdata, rdata, got;
    logic [22:0] pa_func_out, pa_out;
    logic [10:0] pb_pin, pb_func_out, pb_func_oe, pb_func_in, ext_en, ext_val;
    gpio_pkg::pb_pad_t pb_pad;
    logic [23:0] irq_line;
    logic irq, wake, dbus_pu, stop_hold;
    logic [1:0] usb_sel;
    logic [2:0] clkout_sel;
    int bad_count = 0;
    int checks = 0;

    gpio_port_ctrl uut (
        .CLK(clk),
        .RST_B(rst_b),
        .CE(ce),
        .ADDR(addr),
        .WDATA(wdata),
        .WR(wr),
        .RD(rd),
        .RDATA(rdata),
        .PA_FUNC_OUT(pa_func_out),
        .EXT_RESET_PIN_N(ext_rst_n),
        .WATCHDOG_RESET_N(wdt_rst_n),
        .SOFTWARE_RESET_N(sw_rst_n),
        .PA_OUT(pa_out),
        .PB_PIN_IN(pb_pin),
        .PB_FUNC_OUT(pb_func_out),
        .PB_FUNC_OE(pb_func_oe),
        .PB_PAD(pb_pad),
        .PB_FUNC_IN(pb_func_in),
        .EXTERNAL_IRQ_LINE(irq_line),
        .IRQ(irq),
        .WAKE(wake),
        .DBUS_PULLUP_EN(dbus_pu),
        .STOP_HOLD(stop_hold),
        .USB_PAD_SEL(usb_sel),
        .CLKOUT_SEL(clkout_sel)
    );

    gpio_board_model board (
        .CLK(clk),
        .PAD(pb_pad),
        .EXT_EN(ext_en),
        .EXT_VAL(ext_val),
        .PIN(pb_pin)
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic report_and_stop;
        if (bad_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [31:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        rd_reg(a);
        chk(got, e);
    endtask

    task automatic t_reset;
        rchk(gpio_pkg::PB_FSEL_ADDR, 32'h0000_0000);
        rchk(gpio_pkg::PB_PUD_ADDR, 32'h0000_0000);
        rchk(gpio_pkg::PA_FSEL_ADDR, 32'h007F_FFFF);
        chk(pb_pad.pullup_en, 32'h0000_07FF);
        chk(pb_pad.oe, 32'h0000_0000);
        wr_reg(32'h5600_001C, 32'hFFFF_FFFF);
        rchk(32'h5600_001C, 32'h0000_0000);
        rchk(32'h5600_000C, 32'h0000_0000);
        rchk(32'h5600_0008, 32'h0000_0000);
        rchk(gpio_pkg::PB_FSEL_ADDR, 32'h0000_0000);
    endtask

    task automatic t_pb;
        wr_reg(gpio_pkg::PB_FSEL_ADDR, 32'h0015_5555);
        wr_reg(gpio_pkg::PB_DATA_ADDR, 32'h0000_05A5);
        cyc(4);
        chk(pb_pad.oe, 32'h0000_07FF);
        chk(pb_pad.out, 32'h0000_05A5);
        rchk(gpio_pkg::PB_DATA_ADDR, 32'h0000_05A5);
        wr_reg(gpio_pkg::PB_PUD_ADDR, 32'h0000_00F0);
        cyc(3);
        chk(pb_pad.pullup_en, 32'h0000_070F);
        rchk(gpio_pkg::PB_PUD_ADDR, 32'h0000_00F0);
        wr_reg(gpio_pkg::PB_FSEL_ADDR, 32'h0000_0000);
        ext_en <= 11'h7FF;
        ext_val <= 11'h3C3;
        cyc(4);
        chk(pb_pad.oe, 32'h0000_0000);
        rchk(gpio_pkg::PB_DATA_ADDR, 32'h0000_03C3);
        wr_reg(gpio_pkg::PB_FSEL_ADDR, 32'h003F_FFFF);
        cyc(3);
        chk(pb_pad.oe, 32'h0000_0000);
        rchk(gpio_pkg::PB_DATA_ADDR, 32'h0000_03C3);
        @(posedge clk);
        pb_func_out <= 11'h155;
        pb_func_oe <= 11'h0F0;
        ext_en <= 11'h70F;
        wr_reg(gpio_pkg::PB_FSEL_ADDR, 32'h002A_AAAA);
        cyc(4);
        chk(pb_pad.oe, 32'h0000_00F0);
        chk(pb_pad.out & 11'h0F0, 32'h0000_0050);
        chk(pb_func_in & 11'h70F, 32'h0000_0303);
        @(posedge clk);
        ext_en <= 11'h000;
    endtask

    task automatic t_pa;
        wr_reg(gpio_pkg::PA_FSEL_ADDR, 32'h0055_5555);
        wr_reg(gpio_pkg::PA_DATA_ADDR, 32'h0000_0F0F);
        pa_func_out <= 23'h7F_FFFF;
        cyc(4);
        chk(pa_out, 32'h0055_5F5F);
        wr_reg(gpio_pkg::PA_FSEL_ADDR, 32'h007F_FFFF);
        pa_func_out <= 23'h2A_AAAA;
        cyc(4);
        chk(pa_out, 32'h002A_AAAA);
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            {sw_rst_n, wdt_rst_n, ext_rst_n} <= ~(3'h1 << i);
            cyc(6);
            chk(pa_out, 32'h000A_AAAA);
        end
        @(posedge clk);
        {sw_rst_n, wdt_rst_n, ext_rst_n} <= 3'h7;
        cyc(6);
        chk(pa_out, 32'h002A_AAAA);
    endtask

    task automatic t_misc;
        logic [6:0] v;
        for (int i = 0; i < 2; i++) begin
            v = (i == 0) ? 7'h7F : 7'h2A;
            wr_reg(gpio_pkg::MISC_ADDR, {25'h000_0000, v});
            cyc(2);
            chk({clkout_sel, usb_sel, stop_hold, ~dbus_pu}, v);
            rchk(gpio_pkg::MISC_ADDR, {25'h000_0000, v});
        end
    endtask

    task automatic t_irq;
        logic [4:0] start;
        start = 5'h05;
        wr_reg(gpio_pkg::TRIG0_ADDR, 32'h0000_0300);
        wr_reg(gpio_pkg::IRQ_STATUS_ADDR, 32'h00FF_FFFF);
        irq_line[2] <= 1'b1;
        cyc(8);
        rd_reg(gpio_pkg::IRQ_STATUS_ADDR);
        chk(got & 32'h4, 32'h0000_0004);
        chk(irq, 32'h0000_0000);
        wr_reg(gpio_pkg::IRQ_ENABLE_ADDR, 32'h0000_0004);
        cyc(2);
        chk({irq, wake}, 32'h0000_0003);
        for (int c = 0; c < 5; c++) begin
            @(posedge clk);
            irq_line[2] <= start[c];
            wr_reg(gpio_pkg::TRIG0_ADDR, 32'(c) << 8);
            cyc(8);
            wr_reg(gpio_pkg::IRQ_STATUS_ADDR, 32'h0000_0004);
            cyc(4);
            rd_reg(gpio_pkg::IRQ_STATUS_ADDR);
            chk(got & 32'h4, 32'h0000_0000);
            @(posedge clk);
            irq_line[2] <= ~start[c];
            cyc(8);
            rd_reg(gpio_pkg::IRQ_STATUS_ADDR);
            chk({got[2], irq}, 32'h0000_0003);
            wr_reg(gpio_pkg::IRQ_STATUS_ADDR, 32'h0000_0004);
            cyc(8);
            rd_reg(gpio_pkg::IRQ_STATUS_ADDR);
            chk(got[2], (c < 2) ? 1 : 0);
            @(posedge clk);
            irq_line[2] <= start[c];
            cyc(8);
            rd_reg(gpio_pkg::IRQ_STATUS_ADDR);
            chk(got[2], (c < 2 || c == 4) ? 1 : 0);
        end
    endtask

    task automatic t_filt;
        wr_reg(gpio_pkg::IRQ_ENABLE_ADDR, 32'h0000_1000);
        wr_reg(gpio_pkg::TRIG1_ADDR, 32'h0003_0000);
        wr_reg(gpio_pkg::FILT0_ADDR, 32'h000B_0000);
        cyc(8);
        wr_reg(gpio_pkg::IRQ_STATUS_ADDR, 32'h00FF_FFFF);
        irq_line[12] <= 1'b1;
        @(posedge clk);
        irq_line[12] <= 1'b0;
        cyc(12);
        rd_reg(gpio_pkg::IRQ_STATUS_ADDR);
        chk({got[12], irq}, 32'h0000_0000);
        @(posedge clk);
        irq_line[12] <= 1'b1;
        cyc(12);
        rd_reg(gpio_pkg::IRQ_STATUS_ADDR);
        chk({got[12], irq, wake}, 32'h0000_0006);
    endtask

    initial begin
        #(20000 * 8);
        bad_count++;
        report_and_stop();
    end

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 32'h0000_0000;
        wdata = 32'h0000_0000;
        pa_func_out = 23'h00_0000;
        {sw_rst_n, wdt_rst_n, ext_rst_n} = 3'h7;
        pb_func_out = 11'h000;
        pb_func_oe = 11'h000;
        ext_en = 11'h000;
        ext_val = 11'h000;
        irq_line = 24'h00_0000;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_pb();
        t_pa();
        t_misc();
        t_irq();
        t_filt();
        report_and_stop();
    end
endmodule
`default_nettype wire
